// ==== design/rcs_core.sv ====
`timescale 1ns/1ps
module rcs_core import rcs_pkg::*; #(
	parameter int TICK_CYC = RAMP_TICK_CYC, // ramp step period in clocks
	parameter logic [7:0] FW_VER = 8'h14 // firmware version in tenths, arbitrary
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic [7:0] op_live,
	input wire rcs_net_t net_info,
	input wire logic [3:0][7:0] rdg_flags,
	input wire logic [3:0] alarm_low,
	input wire logic [3:0] alarm_high,
	input wire logic power_restore,
	output logic op_summary,
	output rcs_out_t [N_OUT-1:0] loop_cfg,
	output logic [1:0] relay_on,
	output logic cal_start,
	output rcs_cal_t cal_req
);
	rcs_state_t st; // registered state
	rcs_state_t next_st; // next state
	logic tick; // ramp step strobe
	logic [N_LOOP-1:0] ramping; // working setpoint still moving
	logic [1:0] oi; // output index from address
	logic [31:0] rd_val; // read mux result

	assign oi = bus_addr[1:0];
	assign tick = (st.tick_cnt == 32'(TICK_CYC - 1));

	// ramp status per loop
	always_comb
	begin
		for (int l = 0; l < N_LOOP; l++)
		begin
			ramping[l] = (st.out[l].work != st.out[l].target);
		end
	end

	// checks on an output mode write
	function automatic logic mode_ok(input logic [1:0] idx, input logic [2:0] m);
		mode_ok = (m <= M_MIRROR) &&
			!((m == M_MON || m == M_WARM) && idx < 2'(N_LOOP));
	endfunction : mode_ok

	// checks on the control input field
	function automatic logic in_ok(input logic [2:0] m, input logic [3:0] ci);
		in_ok = (ci != 4'h0) && (m == M_MIRROR ? ci <= MIR_MAX : ci <= IN_MAX);
	endfunction : in_ok

	// read mux, live inputs and stored register state, no side effect here
	always_comb
	begin
		rd_val = '0;
		if (bus_addr == A_OPERATIONAL_CONDITION_QUERY)
		begin
			rd_val = {24'h0, op_live};
		end
		else if (bus_addr == A_OPERATIONAL_CONDITION_MASK_WRITE)
		begin
			rd_val = {24'h0, st.op_mask};
		end
		else if (bus_addr == A_LATCHED_CONDITION_QUERY)
		begin
			rd_val = {24'h0, st.op_latch};
		end
		else if (bus_addr == A_NETST)
		begin
			rd_val = {28'h0, net_info.code};
		end
		else if (hit(bus_addr, A_NETADR, 8'(N_NET)))
		begin
			// unconfigured interface reads as zero addresses
			rd_val = net_info.configured ?
				net_info.addr[3'(bus_addr - A_NETADR)] : '0;
		end
		else if (hit(bus_addr, A_MODE, 8'(N_OUT)))
		begin
			rd_val = {23'h0, st.out[oi].pwr_up, st.out[oi].ctl_in, 1'b0, st.out[oi].mode};
		end
		else if (hit(bus_addr, A_RANGE, 8'(N_OUT)))
		begin
			rd_val = {30'h0, st.out[oi].range};
		end
		else if (hit(bus_addr, A_LOOP_TARGET_SET, 8'(N_OUT)))
		begin
			rd_val = st.out[oi].target;
		end
		else if (hit(bus_addr, A_WORK, 8'(N_OUT)))
		begin
			rd_val = st.out[oi].work;
		end
		else if (hit(bus_addr, A_GAIN, 8'(4 * N_OUT)) && oi != 2'(N_GAIN))
		begin
			rd_val = {16'h0, st.out[bus_addr[3:2]].gain[oi]};
		end
		else if (hit(bus_addr, A_RAMP, 8'(N_LOOP)))
		begin
			rd_val = {15'h0, st.ramp[bus_addr[0]].en, 6'h0, st.ramp[bus_addr[0]].rate};
		end
		else if (hit(bus_addr, A_SETPOINT_SLEW_STATE_QUERY, 8'(N_LOOP)))
		begin
			rd_val = {31'h0, ramping[bus_addr[0]]};
		end
		else if (hit(bus_addr, A_INPUT_READING_FLAGS_QUERY, 8'(N_OUT)))
		begin
			rd_val = {24'h0, rdg_flags[oi] & RDG_MASK};
		end
		else if (hit(bus_addr, A_RELAY, 8'h2))
		begin
			rd_val = {26'h0, st.relay[bus_addr[0]].atype, st.relay[bus_addr[0]].sel,
				st.relay[bus_addr[0]].mode};
		end
		else if (hit(bus_addr, A_RELAY_STATE_QUERY, 8'h2))
		begin
			rd_val = {31'h0, st.relay[bus_addr[0]].on};
		end
		else if (bus_addr == A_CAL)
		begin
			rd_val = {12'h0, st.cal.sn_len, 2'h0, st.cal.dest, 5'h0, st.cal.base};
		end
		else if (bus_addr == A_ERR)
		begin
			rd_val = {24'h0, st.err};
		end
		else if (hit(bus_addr, A_CALPT, 8'(N_PT)))
		begin
			rd_val = st.cal.pt[3'(bus_addr - A_CALPT)];
		end
	end

	// next-state logic
	always_comb
	begin
		logic [7:0] err_set;
		logic [2:0] wm;
		logic [3:0] wi;
		logic [1:0] wr;
		logic mapped;
		logic alarm;
		err_set = '0;
		wm = bus_wdata[F_MODE +: 3];
		wi = bus_wdata[F_IN +: 4];
		wr = bus_wdata[1:0];
		mapped = 1'b1;
		alarm = 1'b0;
		next_st = st;
		next_st.cal_start = 1'b0;
		next_st.rdata = bus_rd ? rd_val : '0;
		next_st.tick_cnt = tick ? '0 : st.tick_cnt + 32'h1;
		// summary follows live bits under the mask
		next_st.summary = |(op_live & st.op_mask);
		// latched copy: reading clears, a new condition wins
		next_st.op_latch = ((bus_rd && bus_addr == A_LATCHED_CONDITION_QUERY) ? 8'h0 : st.op_latch)
			| op_live;
		// register writes
		if (bus_wr)
		begin
			if (bus_addr == A_OPERATIONAL_CONDITION_MASK_WRITE)
			begin
				next_st.op_mask = bus_wdata[7:0];
			end
			else if (hit(bus_addr, A_MODE, 8'(N_OUT)))
			begin
				if (!mode_ok(oi, wm))
				begin
					err_set[E_MODE] = 1'b1;
				end
				else if (!in_ok(wm, wi))
				begin
					err_set[E_IN] = 1'b1;
				end
				else
				begin
					next_st.out[oi].mode = wm;
					next_st.out[oi].ctl_in = wi;
					next_st.out[oi].pwr_up = bus_wdata[F_PWR];
				end
			end
			else if (hit(bus_addr, A_RANGE, 8'(N_OUT)))
			begin
				// heater outputs take four codes, analog outputs two
				if (wr > (oi < 2'(N_LOOP) ? RNG_HEAT_MAX : RNG_ANA_MAX) ||
					bus_wdata[31:2] != '0)
				begin
					err_set[E_RNG] = 1'b1;
				end
				else
				begin
					next_st.out[oi].range = wr;
					next_st.out[oi].enabled = 1'b1;
				end
			end
			else if (hit(bus_addr, A_LOOP_TARGET_SET, 8'(N_OUT)))
			begin
				// analog outputs only take a setpoint in warm-up
				if (oi >= 2'(N_LOOP) && st.out[oi].mode != M_WARM)
				begin
					err_set[E_LOOP_TARGET_SET] = 1'b1;
				end
				else
				begin
					next_st.out[oi].target = bus_wdata;
				end
			end
			else if (hit(bus_addr, A_GAIN, 8'(4 * N_OUT)) && oi != 2'(N_GAIN))
			begin
				next_st.out[bus_addr[3:2]].gain[oi] = bus_wdata[15:0];
			end
			else if (hit(bus_addr, A_RAMP, 8'(N_LOOP)))
			begin
				if (bus_wdata[F_RATE +: 10] > RATE_MAX)
				begin
					err_set[E_RATE] = 1'b1;
				end
				else
				begin
					next_st.ramp[bus_addr[0]].en = bus_wdata[F_REN];
					next_st.ramp[bus_addr[0]].rate = bus_wdata[F_RATE +: 10];
				end
			end
			else if (hit(bus_addr, A_RELAY, 8'h2))
			begin
				next_st.relay[bus_addr[0]].mode = bus_wdata[1:0];
				next_st.relay[bus_addr[0]].sel = bus_wdata[F_RSEL +: 2];
				next_st.relay[bus_addr[0]].atype = bus_wdata[F_RTYPE +: 2];
			end
			else if (hit(bus_addr, A_CALPT, 8'(N_PT)))
			begin
				next_st.cal.pt[3'(bus_addr - A_CALPT)] = bus_wdata;
			end
			else if (bus_addr == A_CAL)
			begin
				if (FW_VER >= CAL_GONE_VER)
				begin
					err_set[E_GONE] = 1'b1;
				end
				else if (!(wm == CB_A || wm == CB_B || wm == CB_C) ||
					bus_wdata[F_DEST +: 6] < CD_MIN || bus_wdata[F_DEST +: 6] > CD_MAX ||
					bus_wdata[F_SN +: 4] > SN_MAX)
				begin
					err_set[E_CAL] = 1'b1;
				end
				else
				begin
					next_st.cal.base = wm;
					next_st.cal.dest = bus_wdata[F_DEST +: 6];
					next_st.cal.sn_len = bus_wdata[F_SN +: 4];
					next_st.cal_start = 1'b1;
				end
			end
			else
			begin
				mapped = 1'b0;
			end
		end
		err_set[E_ADDR] = bus_wr && !mapped;
		// error flags: read clears, a new error wins
		next_st.err = ((bus_rd && bus_addr == A_ERR) ? 8'h0 : st.err) | err_set;
		// power cycle: outputs come back only where the flag asks
		if (power_restore)
		begin
			for (int o = 0; o < N_OUT; o++)
			begin
				next_st.out[o].enabled = st.out[o].pwr_up;
			end
		end
		// working setpoint ramps toward target on heater loops
		for (int o = 0; o < N_OUT; o++)
		begin
			if (o < N_LOOP && st.ramp[o].en && st.ramp[o].rate != '0)
			begin
				if (tick && $signed(st.out[o].target) > $signed(st.out[o].work))
				begin
					next_st.out[o].work = ($signed(st.out[o].target - st.out[o].work) >
						$signed({22'h0, st.ramp[o].rate})) ?
						st.out[o].work + {22'h0, st.ramp[o].rate} : st.out[o].target;
				end
				else if (tick && $signed(st.out[o].target) < $signed(st.out[o].work))
				begin
					next_st.out[o].work = ($signed(st.out[o].work - st.out[o].target) >
						$signed({22'h0, st.ramp[o].rate})) ?
						st.out[o].work - {22'h0, st.ramp[o].rate} : st.out[o].target;
				end
			end
			else
			begin
				next_st.out[o].work = st.out[o].target;
			end
			// drive: off never, monitor always, else range and enable
			if (st.out[o].mode == M_OFF)
			begin
				next_st.out[o].on = 1'b0;
			end
			else if (st.out[o].mode == M_MON)
			begin
				next_st.out[o].on = 1'b1;
			end
			else
			begin
				next_st.out[o].on = st.out[o].enabled && st.out[o].range != '0;
			end
		end
		// relays
		for (int r = 0; r < 2; r++)
		begin
			unique case (st.relay[r].atype)
				AT_LOW: alarm = alarm_low[st.relay[r].sel];
				AT_HIGH: alarm = alarm_high[st.relay[r].sel];
				default: alarm = alarm_low[st.relay[r].sel] | alarm_high[st.relay[r].sel];
			endcase
			next_st.relay[r].on = (st.relay[r].mode == RLY_ON) ||
				(st.relay[r].mode == RLY_ALARM && alarm);
		end
	end

	// state register
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign bus_rdata = st.rdata;
	assign op_summary = st.summary;
	assign loop_cfg = st.out;
	assign relay_on = {st.relay[1].on, st.relay[0].on};
	assign cal_start = st.cal_start;
	assign cal_req = st.cal;

	// checks
	sequence s_rd(logic [7:0] a);
		bus_rd && bus_addr == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		bus_wr && bus_addr == a;
	endsequence

	property p_operational_condition_query_value;
		@(posedge ref_clk) disable iff (!rstn) s_rd(A_OPERATIONAL_CONDITION_QUERY) |=> bus_rdata == {24'h0, $past(op_live)};
	endproperty
	a_operational_condition_query_value: assert property (p_operational_condition_query_value) else $error("live status read wrong");

	property p_summary;
		@(posedge ref_clk) disable iff (!rstn) 1'b1 |=> op_summary == |($past(op_live & st.op_mask));
	endproperty
	a_summary: assert property (p_summary) else $error("summary not masked or");

	property p_latch_clear;
		@(posedge ref_clk) disable iff (!rstn) s_rd(A_LATCHED_CONDITION_QUERY) ##0 op_live == 8'h0 |=> st.op_latch == 8'h0;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared by read");

	property p_operational_condition_query_keep;
		@(posedge ref_clk) disable iff (!rstn) s_rd(A_OPERATIONAL_CONDITION_QUERY) |=> (($past(st.op_latch) & ~st.op_latch) == 8'h0);
	endproperty
	a_operational_condition_query_keep: assert property (p_operational_condition_query_keep) else $error("live read cleared latch");

	property p_mode_reject;
		@(posedge ref_clk) disable iff (!rstn)
			s_wr(A_MODE) ##0 (bus_wdata[2:0] == M_MON) |=> $stable(st.out[0].mode);
	endproperty
	a_mode_reject: assert property (p_mode_reject) else $error("monitor mode taken on heater");

	property p_monitor_on;
		@(posedge ref_clk) disable iff (!rstn) st.out[2].mode == M_MON |=> loop_cfg[2].on;
	endproperty
	a_monitor_on: assert property (p_monitor_on) else $error("monitor output not on");

	property p_zero_rate;
		@(posedge ref_clk) disable iff (!rstn)
			s_wr(A_LOOP_TARGET_SET) ##0 (st.ramp[0].rate == '0) ##1 (st.ramp[0].rate == '0) |=>
			loop_cfg[0].work == loop_cfg[0].target;
	endproperty
	a_zero_rate: assert property (p_zero_rate) else $error("zero rate did not step");

	property p_cal_gone;
		@(posedge ref_clk) disable iff (!rstn) FW_VER >= CAL_GONE_VER |-> !cal_start;
	endproperty
	a_cal_gone: assert property (p_cal_gone) else $error("curve generation after removal");

	property p_relay_alarm;
		@(posedge ref_clk) disable iff (!rstn)
			st.relay[0].mode == RLY_ALARM && st.relay[0].atype == AT_HIGH |=>
			relay_on[0] == $past(alarm_high[st.relay[0].sel]);
	endproperty
	a_relay_alarm: assert property (p_relay_alarm) else $error("relay not following alarm");
endmodule : rcs_core

// ==== design/rcs_pkg.sv ====
// Summary of operation
// - status query returns weighted sum of set bits
// - enable mask gates bits onto summary
// - latched copy sets on condition, clears on read
// - network query reports link status code one to nine
// - unconfigured network reports all-zero addresses
// - output mode codes zero through six
// - monitor and warm-up only on outputs 3, 4
// - control input selects sensor or mirrored output
// - power-up flag keeps output on after power cycle
// - gains and setpoint stored per output loop
// - ramp enable per loop, rate 0.1 to 100
// - unsigned rate moves working setpoint both ways
// - zero rate steps setpoint immediately
// - ramp status one while still moving
// - range codes 0-3 heaters, 0-1 analog outputs
// - range ignored when off, monitor always on
// - input flags weighted, zero means valid reading
// - alarm relay follows low, high or either alarm
// - two relays, status zero off one energised
// - analog output setpoint valid only in warm-up
// - curve generation takes base, destination, serial, points
// - curve generation refused from version 3.0
package rcs_pkg;
	// register addresses
	localparam logic [7:0] A_OPERATIONAL_CONDITION_QUERY = 8'h00;
	localparam logic [7:0] A_OPERATIONAL_CONDITION_MASK_WRITE = 8'h01;
	localparam logic [7:0] A_LATCHED_CONDITION_QUERY = 8'h02;
	localparam logic [7:0] A_NETST = 8'h03;
	localparam logic [7:0] A_NETADR = 8'h04;
	localparam logic [7:0] A_MODE = 8'h10;
	localparam logic [7:0] A_RANGE = 8'h14;
	localparam logic [7:0] A_LOOP_TARGET_SET = 8'h18;
	localparam logic [7:0] A_WORK = 8'h1c;
	localparam logic [7:0] A_GAIN = 8'h20;
	localparam logic [7:0] A_RAMP = 8'h30;
	localparam logic [7:0] A_SETPOINT_SLEW_STATE_QUERY = 8'h32;
	localparam logic [7:0] A_INPUT_READING_FLAGS_QUERY = 8'h34;
	localparam logic [7:0] A_RELAY = 8'h38;
	localparam logic [7:0] A_RELAY_STATE_QUERY = 8'h3a;
	localparam logic [7:0] A_CAL = 8'h3c;
	localparam logic [7:0] A_ERR = 8'h3f;
	localparam logic [7:0] A_CALPT = 8'h40;
	// counts of things
	localparam int N_OUT = 4;
	localparam int N_LOOP = 2;
	localparam int N_NET = 5;
	localparam int N_PT = 6;
	localparam int N_GAIN = 3;
	// output modes
	localparam logic [2:0] M_OFF = 3'h0;
	localparam logic [2:0] M_PID = 3'h1;
	localparam logic [2:0] M_MIRROR = 3'h6;
	localparam logic [2:0] M_MON = 3'h4;
	localparam logic [2:0] M_WARM = 3'h5;
	localparam logic [3:0] IN_MAX = 4'h8;
	localparam logic [3:0] MIR_MAX = 4'h4;
	localparam logic [1:0] RNG_HEAT_MAX = 2'h3;
	localparam logic [1:0] RNG_ANA_MAX = 2'h1;
	// write-data field positions
	localparam int F_MODE = 0;
	localparam int F_IN = 4;
	localparam int F_PWR = 8;
	localparam int F_RATE = 0;
	localparam int F_REN = 16;
	localparam int F_RSEL = 2;
	localparam int F_RTYPE = 4;
	localparam int F_DEST = 8;
	localparam int F_SN = 16;
	// ramp rate in tenths of K/min, setpoint in tenths of mK
	localparam logic [9:0] RATE_MAX = 10'h3e8;
	localparam int RAMP_TICK_MS = 60;
	localparam int CLK_HZ = 40000000;
	localparam int RAMP_TICK_CYC = CLK_HZ / 1000 * RAMP_TICK_MS;
	// input flag weights kept in the reading status
	localparam logic [7:0] RDG_MASK = 8'hf1;
	// relay modes and alarm types
	localparam logic [1:0] RLY_ON = 2'h1;
	localparam logic [1:0] RLY_ALARM = 2'h2;
	localparam logic [1:0] AT_LOW = 2'h0;
	localparam logic [1:0] AT_HIGH = 2'h1;
	// curve generation limits and removal version (tenths)
	localparam logic [2:0] CB_A = 3'h1;
	localparam logic [2:0] CB_B = 3'h6;
	localparam logic [2:0] CB_C = 3'h7;
	localparam logic [5:0] CD_MIN = 6'h15;
	localparam logic [5:0] CD_MAX = 6'h3b;
	localparam logic [3:0] SN_MAX = 4'ha;
	localparam logic [7:0] CAL_GONE_VER = 8'h1e;
	// error flag positions
	localparam int E_MODE = 0;
	localparam int E_IN = 1;
	localparam int E_RNG = 2;
	localparam int E_LOOP_TARGET_SET = 3;
	localparam int E_RATE = 4;
	localparam int E_CAL = 5;
	localparam int E_GONE = 6;
	localparam int E_ADDR = 7;

	// network facts from the link side
	typedef struct packed {
		logic [3:0] code;
		logic configured;
		logic [N_NET-1:0][31:0] addr;
	} rcs_net_t;

	// per-output loop settings
	typedef struct packed {
		logic [2:0] mode;
		logic [3:0] ctl_in;
		logic pwr_up;
		logic enabled;
		logic [1:0] range;
		logic on;
		logic [N_GAIN-1:0][15:0] gain;
		logic [31:0] target;
		logic [31:0] work;
	} rcs_out_t;

	// ramp setting of one heater loop
	typedef struct packed {
		logic en;
		logic [9:0] rate;
	} rcs_ramp_t;

	// relay configuration and drive
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] sel;
		logic [1:0] atype;
		logic on;
	} rcs_relay_t;

	// accepted curve generation request
	typedef struct packed {
		logic [2:0] base;
		logic [5:0] dest;
		logic [3:0] sn_len;
		logic [N_PT-1:0][31:0] pt;
	} rcs_cal_t;

	// all block state
	typedef struct packed {
		logic [7:0] op_mask;
		logic [7:0] op_latch;
		logic summary;
		rcs_out_t [N_OUT-1:0] out;
		rcs_ramp_t [N_LOOP-1:0] ramp;
		logic [31:0] tick_cnt;
		rcs_relay_t [1:0] relay;
		rcs_cal_t cal;
		logic cal_start;
		logic [7:0] err;
		logic [31:0] rdata;
	} rcs_state_t;

	// true when addr falls in [base, base+n)
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] base,
		input logic [7:0] n);
		hit = (addr >= base) && (addr < base + n);
	endfunction : hit
endpackage : rcs_pkg

// ==== verif/rcs_src_model.sv ====
`timescale 1ns/1ps
// stand-in for the sensor, alarm and link sources behind the block
module rcs_src_model import rcs_pkg::*; (
	input wire logic ref_clk,
	output logic [7:0] op_live,
	output rcs_net_t net_info,
	output logic [3:0][7:0] rdg_flags,
	output logic [3:0] alarm_low,
	output logic [3:0] alarm_high,
	output logic power_restore
);
	// quiet sources at time zero; address words are junk and stay junk when configured
	initial
	begin
		op_live = 8'h00;
		net_info = '0;
		net_info.addr = {N_NET{32'h5a5a_a5a5}};
		rdg_flags = '0;
		alarm_low = 4'h0;
		alarm_high = 4'h0;
		power_restore = 1'b0;
	end
	// new live status just after an edge
	task automatic set_live(input logic [7:0] v);
		@(posedge ref_clk);
		op_live <= v;
	endtask : set_live
	// link code and configured flag; address words keep their junk
	task automatic set_net(input logic [3:0] code, input logic cfg);
		@(posedge ref_clk);
		net_info.code <= code;
		net_info.configured <= cfg;
	endtask : set_net
	// reading flags of one input
	task automatic set_flags(input int idx, input logic [7:0] v);
		@(posedge ref_clk);
		rdg_flags[idx] <= v;
	endtask : set_flags
	// alarm levels of all inputs
	task automatic set_alarm(input logic [3:0] lo, input logic [3:0] hi);
		@(posedge ref_clk);
		alarm_low <= lo;
		alarm_high <= hi;
	endtask : set_alarm
	// one-cycle power restore event
	task automatic pulse_restore;
		@(posedge ref_clk);
		power_restore <= 1'b1;
		@(posedge ref_clk);
		power_restore <= 1'b0;
	endtask : pulse_restore
endmodule : rcs_src_model

// ==== verif/tb_rcs_core.sv ====
`timescale 1ns/1ps
// register-level checks of the remote command block
module tb_rcs_core import rcs_pkg::*;;
	logic ref_clk;
	logic rstn;
	logic [7:0] bus_addr;
	logic [31:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] bus_rdata;
	logic [31:0] bus_rdata_new; // late firmware copy
	logic [7:0] op_live;
	rcs_net_t net_info;
	logic [3:0][7:0] rdg_flags;
	logic [3:0] alarm_low;
	logic [3:0] alarm_high;
	logic power_restore;
	logic op_summary;
	rcs_out_t [N_OUT-1:0] loop_cfg;
	logic [1:0] relay_on;
	logic cal_start;
	logic cal_start_new;
	logic op_summary_new; // summary of the late firmware copy
	rcs_cal_t cal_req; // accepted curve request
	rcs_cal_t cal_req_new; // curve request of the late copy, dest must stay zero
	int n_fail;
	int check_count;
	int n_cal = 0; // curve starts seen
	int n_cal_new = 0;
	logic [31:0] d;
	logic [31:0] e1;
	logic [31:0] e3;
	logic bad;
	int n;

	// short tick keeps ramps quick
	rcs_core #(.TICK_CYC(4)) i_rcs_core (.ref_clk(ref_clk), .rstn(rstn),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .op_live(op_live), .net_info(net_info),
		.rdg_flags(rdg_flags), .alarm_low(alarm_low), .alarm_high(alarm_high),
		.power_restore(power_restore), .op_summary(op_summary), .loop_cfg(loop_cfg),
		.relay_on(relay_on), .cal_start(cal_start), .cal_req(cal_req));
	// copy at version 3.0 shares the bus
	rcs_core #(.TICK_CYC(4), .FW_VER(8'h1e)) i_rcs_core_new (.ref_clk(ref_clk),
		.rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata_new), .op_live(op_live),
		.net_info(net_info), .rdg_flags(rdg_flags), .alarm_low(alarm_low),
		.alarm_high(alarm_high), .power_restore(power_restore),
		.op_summary(op_summary_new), .loop_cfg(), .relay_on(),
		.cal_start(cal_start_new), .cal_req(cal_req_new));
	rcs_src_model i_rcs_src_model (.ref_clk(ref_clk), .op_live(op_live),
		.net_info(net_info), .rdg_flags(rdg_flags), .alarm_low(alarm_low),
		.alarm_high(alarm_high), .power_restore(power_restore));

	// 40 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// count curve start pulses of both copies
	always @(posedge ref_clk)
	begin
		if (cal_start === 1'b1)
			n_cal <= n_cal + 1;
		if (cal_start_new === 1'b1)
			n_cal_new <= n_cal_new + 1;
	end
	// counts, verdict and end of run
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	// compare seen against expected
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : wr
	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
	endtask : rd
	// read and compare
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(v, exp);
	endtask : rdc
	// let registered outputs land
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle
	// poll ramp status of loop 1 until idle, bounded
	task automatic wait_ramp;
		n = 0;
		d = 32'h1;
		while (d !== 32'h0 && n < 100)
		begin
			rd(A_SETPOINT_SLEW_STATE_QUERY, d);
			n++;
		end
		if (d !== 32'h0)
		begin
			n_fail++;
			$display("[FAIL] %0t ramp never settled", $time);
			complete_run();
		end
	endtask : wait_ramp
	// watchdog against a hang
	initial
	begin
		repeat (50000) @(posedge ref_clk);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end

	// main sequence
	initial
	begin
		n_fail = 0;
		check_count = 0;
		rstn = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		rdc(A_OPERATIONAL_CONDITION_MASK_WRITE, 32'h0);
		// live status, non-destructive read, latched copy
		i_rcs_src_model.set_live(8'h05);
		rdc(A_OPERATIONAL_CONDITION_QUERY, 32'h05);
		rdc(A_OPERATIONAL_CONDITION_QUERY, 32'h05);
		i_rcs_src_model.set_live(8'h00);
		rdc(A_LATCHED_CONDITION_QUERY, 32'h05);
		rdc(A_LATCHED_CONDITION_QUERY, 32'h00);
		// summary gated by mask
		wr(A_OPERATIONAL_CONDITION_MASK_WRITE, 32'h04);
		i_rcs_src_model.set_live(8'h0b);
		settle();
		chk({31'h0, op_summary}, 32'h0);
		i_rcs_src_model.set_live(8'h04);
		settle();
		chk({31'h0, op_summary}, 32'h1);
		chk({31'h0, op_summary_new}, 32'h1);
		wr(A_OPERATIONAL_CONDITION_MASK_WRITE, 32'h08);
		settle();
		chk({31'h0, op_summary}, 32'h0);
		// every link code, then unconfigured addresses
		for (int i = 1; i < 10; i++)
		begin
			i_rcs_src_model.set_net(4'(i), 1'b1);
			rdc(A_NETST, 32'(i));
		end
		rdc(A_NETADR, 32'h5a5a_a5a5);
		i_rcs_src_model.set_net(4'h6, 1'b0);
		for (int i = 0; i < N_NET; i++)
			rdc(A_NETADR + 8'(i), 32'h0);
		// all mode codes on a heater and an analog output
		e1 = 32'h0;
		e3 = 32'h0;
		for (int i = 0; i < 8; i++)
		begin
			bad = (i == 4 || i == 5 || i == 7);
			wr(A_MODE, 32'h10 | 32'(i));
			wr(A_MODE + 8'h2, 32'h10 | 32'(i));
			if (!bad)
				e1 = 32'h10 | 32'(i);
			if (i != 7)
				e3 = 32'h10 | 32'(i);
			rdc(A_MODE, e1);
			rdc(A_MODE + 8'h2, e3);
			rdc(A_ERR, {31'h0, bad});
		end
		// control input limits, mirror limits
		wr(A_MODE + 8'h1, 32'h81);
		wr(A_MODE + 8'h1, 32'h91);
		rdc(A_ERR, 32'h2);
		wr(A_MODE + 8'h1, 32'h56);
		rdc(A_ERR, 32'h2);
		wr(A_MODE + 8'h1, 32'h46);
		rdc(A_MODE + 8'h1, 32'h46);
		// range limits per output kind
		wr(A_RANGE, 32'h3);
		wr(A_RANGE, 32'h4);
		rdc(A_RANGE, 32'h3);
		rdc(A_ERR, 32'h4);
		wr(A_RANGE + 8'h2, 32'h2);
		rdc(A_ERR, 32'h4);
		wr(A_RANGE + 8'h2, 32'h1);
		rdc(A_RANGE + 8'h2, 32'h1);
		// monitor always on, off ignores range
		wr(A_MODE + 8'h3, 32'h14);
		settle();
		chk({31'h0, loop_cfg[3].on}, 32'h1);
		wr(A_MODE + 8'h1, 32'h10);
		wr(A_RANGE + 8'h1, 32'h2);
		settle();
		chk({31'h0, loop_cfg[1].on}, 32'h0);
		wr(A_MODE + 8'h1, 32'h11);
		settle();
		chk({31'h0, loop_cfg[1].on}, 32'h1);
		// power-up flag decides state after restore
		wr(A_MODE, 32'h11);
		i_rcs_src_model.pulse_restore();
		settle();
		chk({31'h0, loop_cfg[0].on}, 32'h0);
		wr(A_MODE, 32'h111);
		i_rcs_src_model.pulse_restore();
		settle();
		chk({31'h0, loop_cfg[0].enabled}, 32'h1);
		chk({31'h0, loop_cfg[0].on}, 32'h1);
		// gains stored per output
		wr(A_GAIN + 8'h6, 32'h32);
		settle();
		chk({16'h0, loop_cfg[1].gain[2]}, 32'h32);
		rdc(A_GAIN + 8'h6, 32'h32);
		// ramp up and down at 1.0 K/min, then zero rate
		wr(A_RAMP, 32'h1000a);
		wr(A_LOOP_TARGET_SET, 32'd100);
		rdc(A_SETPOINT_SLEW_STATE_QUERY, 32'h1);
		wait_ramp();
		chk({31'h0, n > 10}, 32'h1);
		rdc(A_WORK, 32'd100);
		wr(A_LOOP_TARGET_SET, 32'd0);
		rdc(A_SETPOINT_SLEW_STATE_QUERY, 32'h1);
		wait_ramp();
		rdc(A_WORK, 32'd0);
		wr(A_RAMP, 32'h10000);
		wr(A_LOOP_TARGET_SET, 32'd500);
		rdc(A_SETPOINT_SLEW_STATE_QUERY, 32'h0);
		rdc(A_WORK, 32'd500);
		wr(A_RAMP, 32'h103e8);
		wr(A_RAMP, 32'h103e9);
		rdc(A_RAMP, 32'h103e8);
		rdc(A_ERR, 32'h10);
		// analog setpoint needs warm-up mode
		wr(A_LOOP_TARGET_SET + 8'h2, 32'd7);
		rdc(A_ERR, 32'h8);
		wr(A_MODE + 8'h2, 32'h15);
		wr(A_LOOP_TARGET_SET + 8'h2, 32'd7);
		rdc(A_LOOP_TARGET_SET + 8'h2, 32'd7);
		// reading flags keep only the weighted bits
		i_rcs_src_model.set_flags(1, 8'hff);
		rdc(A_INPUT_READING_FLAGS_QUERY + 8'h1, 32'hf1);
		i_rcs_src_model.set_flags(1, 8'h00);
		rdc(A_INPUT_READING_FLAGS_QUERY + 8'h1, 32'h0);
		// relay 1 in alarm mode on input B, every alarm type
		for (int t = 0; t < 3; t++)
		begin
			wr(A_RELAY, 32'(t << 4) | 32'h6);
			i_rcs_src_model.set_alarm(4'h2, 4'h0);
			rdc(A_RELAY_STATE_QUERY, {31'h0, t != 1});
			chk({31'h0, relay_on[0]}, {31'h0, t != 1});
			i_rcs_src_model.set_alarm(4'h0, 4'h2);
			rdc(A_RELAY_STATE_QUERY, {31'h0, t != 0});
			chk({31'h0, relay_on[0]}, {31'h0, t != 0});
		end
		rdc(A_RELAY, 32'h26);
		wr(A_RELAY + 8'h1, 32'h1);
		rdc(A_RELAY_STATE_QUERY + 8'h1, 32'h1);
		// curve generation, bad arguments, late firmware
		wr(A_CALPT + 8'h5, 32'h1234);
		rdc(A_CALPT + 8'h5, 32'h1234);
		rdc(A_ERR, 32'h0);
		wr(A_CAL, 32'h000a1501);
		rd(A_ERR, d);
		chk(d, 32'h0);
		chk(bus_rdata_new, 32'h40);
		wr(A_CAL, 32'h000b1501);
		wr(A_CAL, 32'h000a3c07);
		wr(A_CAL, 32'h000a3b02);
		rdc(A_ERR, 32'h20);
		settle();
		chk(32'(n_cal), 32'h1);
		chk(32'(n_cal_new), 32'h0);
		chk({12'h0, cal_req.sn_len, 2'h0, cal_req.dest, 5'h0, cal_req.base}, 32'h000a1501);
		chk(cal_req.pt[5], 32'h1234);
		chk(32'(cal_req_new.dest), 32'h0);
		// unmapped place
		wr(8'h50, 32'h1);
		rdc(8'h50, 32'h0);
		rdc(A_ERR, 32'h80);
		complete_run();
	end
endmodule : tb_rcs_core
